/* File: common/iossi_pkg.sv */
// package for the i/o startup status indicator sequencer
package iossi_pkg;

    // ------------------------------------------------------------
    // phase timing (cycles of the 40 mhz clock)
    // ------------------------------------------------------------
    localparam int unsigned IOSSI_CLOCK_MHZ = 40;
    localparam int unsigned IOSSI_PHASE_US = 100;
    localparam int unsigned IOSSI_PHASE_CYCLES =
        IOSSI_PHASE_US * IOSSI_CLOCK_MHZ;
    localparam int unsigned IOSSI_CYCLE_US = 10;
    localparam int unsigned IOSSI_CYCLE_CYCLES =
        IOSSI_CYCLE_US * IOSSI_CLOCK_MHZ;
    localparam int unsigned IOSSI_COUNT_WIDTH = 16;

    // ------------------------------------------------------------
    // indicator patterns {error, bus_a, bus_b, run}
    // ------------------------------------------------------------
    localparam logic [3:0] IOSSI_LED_RESET = 4'h0;
    localparam logic [3:0] IOSSI_LED_COORD_A = 4'h0;
    localparam logic [3:0] IOSSI_LED_COORD_B = 4'h4;
    localparam logic [3:0] IOSSI_LED_SELFTEST = 4'h6;
    localparam logic [3:0] IOSSI_LED_BUS_1 = 4'h2;
    localparam logic [3:0] IOSSI_LED_BUS_2 = 4'h7;
    localparam logic [3:0] IOSSI_LED_RUN = 4'h1;
    localparam logic [3:0] IOSSI_LED_ERR_LOCAL_RAM = 4'hc;
    localparam logic [3:0] IOSSI_LED_ERR_DUAL_PORT_RAM = 4'ha;
    localparam logic [3:0] IOSSI_LED_ERR_ADDRESS_BUS = 4'he;
    localparam logic [3:0] IOSSI_LED_ERR_PROGRAM_MEMORY = 4'h8;
    localparam logic [3:0] IOSSI_LED_ERR_WATCHDOG = 4'hf;

    // self-test error kinds
    typedef enum logic [2:0] {
        IOSSI_ERR_NONE = 3'h0,
        IOSSI_ERR_LOCAL_RAM = 3'h1,
        IOSSI_ERR_DUAL_PORT_RAM = 3'h2,
        IOSSI_ERR_ADDRESS_BUS = 3'h3,
        IOSSI_ERR_PROGRAM_MEMORY = 3'h4,
        IOSSI_ERR_WATCHDOG = 3'h5
    } iossi_error_t;

    // sequencer states, gray coded along the startup path
    typedef enum logic [3:0] {
        IOSSI_COORD_A = 4'h0,
        IOSSI_COORD_B = 4'h1,
        IOSSI_FETCH = 4'h3,
        IOSSI_SELFTEST = 4'h2,
        IOSSI_BUS_1 = 4'h6,
        IOSSI_BUS_2 = 4'h7,
        IOSSI_CYCLIC = 4'h5,
        IOSSI_HALT = 4'hc
    } iossi_state_t;

    // indicator outputs as one carrier
    typedef struct packed {
        logic error_indicator;
        logic bus_a_indicator;
        logic bus_b_indicator;
        logic run_indicator;
    } iossi_leds_t;

endpackage

/* File: hdl/iossi_sequencer.sv */
// startup, self-test and cyclic sequencer with front-panel indicators
// Behaviour
// - every startup runs initialization and self-test before bus bring-up
// - fetch configuration at startup, process it periodically when cyclic
// - indicators: off, A; A+B; B; A+B+run; run alone
// - dark intervals between phases are allowed and not errors
// - bus bring-up starts only after self-test passes without error
// - self-test error halts startup, error indicator lit until reset
// - halt pattern on bus A, bus B, run encodes the error type
// - after bring-up run cyclically, updating image each cycle, run only lit
// - run indicator lit alone marks success; image keeps refreshing while run is lit alone
// - the i/o bus is split into two branches, bus A and bus B
`timescale 1ns/1ps
`default_nettype none

module iossi_sequencer
    import iossi_pkg::*;
#(
    parameter int unsigned PHASE_CYCLES = IOSSI_PHASE_CYCLES,
    parameter int unsigned CYCLE_CYCLES = IOSSI_CYCLE_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // configuration fetch from host memory
    output logic config_fetch_request,
    input wire logic config_fetch_done,
    // self-test engine
    output logic self_test_start,
    input wire logic self_test_done,
    input wire iossi_pkg::iossi_error_t self_test_error,
    // i/o bus branches
    output logic bus_a_bring_up,
    output logic bus_b_bring_up,
    input wire logic bus_bring_up_done,
    output logic image_update,
    // status
    output logic halted,
    output iossi_pkg::iossi_leds_t leds
);
    import iossi_pkg::*;

    iossi_state_t state;
    iossi_state_t next_state;
    logic [IOSSI_COUNT_WIDTH-1:0] timer;
    logic [IOSSI_COUNT_WIDTH-1:0] cycle_timer;
    iossi_error_t error_kind;
    logic phase_done;

    assign phase_done = (timer == IOSSI_COUNT_WIDTH'(PHASE_CYCLES - 1));

    // ------------------------------------------------------------
    // stop pattern decode
    // ------------------------------------------------------------
    // codes outside the table show the error lamp alone
    function automatic iossi_leds_t halt_pattern(input iossi_error_t kind);
        case (kind)
            IOSSI_ERR_LOCAL_RAM: begin
                return IOSSI_LED_ERR_LOCAL_RAM;
            end
            IOSSI_ERR_DUAL_PORT_RAM: begin
                return IOSSI_LED_ERR_DUAL_PORT_RAM;
            end
            IOSSI_ERR_ADDRESS_BUS: begin
                return IOSSI_LED_ERR_ADDRESS_BUS;
            end
            IOSSI_ERR_WATCHDOG: begin
                return IOSSI_LED_ERR_WATCHDOG;
            end
            default: begin
                return IOSSI_LED_ERR_PROGRAM_MEMORY;
            end
        endcase
    endfunction

    // ------------------------------------------------------------
    // state sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            IOSSI_COORD_A: begin
                if (phase_done) begin
                    next_state = IOSSI_COORD_B;
                end
            end
            IOSSI_COORD_B: begin
                if (phase_done) begin
                    next_state = IOSSI_FETCH;
                end
            end
            IOSSI_FETCH: begin
                if (config_fetch_done) begin
                    next_state = IOSSI_SELFTEST;
                end
            end
            IOSSI_SELFTEST: begin
                if (self_test_done) begin
                    if (self_test_error != IOSSI_ERR_NONE) begin
                        next_state = IOSSI_HALT;
                    end else begin
                        next_state = IOSSI_BUS_1;
                    end
                end
            end
            IOSSI_BUS_1: begin
                if (phase_done) begin
                    next_state = IOSSI_BUS_2;
                end
            end
            IOSSI_BUS_2: begin
                if (bus_bring_up_done && phase_done) begin
                    next_state = IOSSI_CYCLIC;
                end
            end
            IOSSI_CYCLIC: next_state = IOSSI_CYCLIC;
            IOSSI_HALT: next_state = IOSSI_HALT;
            default: next_state = IOSSI_COORD_A;
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= IOSSI_COORD_A;
        end else begin
            state <= next_state;
        end
    end

    // phase timer restarts on every state change
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            timer <= '0;
        end else if (next_state != state || phase_done) begin
            timer <= '0;
        end else begin
            timer <= timer + 1'b1;
        end
    end

    // error type captured once, held until reset
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            error_kind <= IOSSI_ERR_NONE;
        end else if (state == IOSSI_SELFTEST && self_test_done) begin
            error_kind <= self_test_error;
        end
    end

    // ------------------------------------------------------------
    // cyclic image refresh
    // ------------------------------------------------------------
    // divider for the refresh rate, idle outside cyclic mode
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cycle_timer <= '0;
        end else if (state != IOSSI_CYCLIC) begin
            cycle_timer <= '0;
        end else if (cycle_timer == IOSSI_COUNT_WIDTH'(CYCLE_CYCLES - 1)) begin
            cycle_timer <= '0;
        end else begin
            cycle_timer <= cycle_timer + 1'b1;
        end
    end

    // one-cycle refresh strobe at each divider wrap
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            image_update <= 1'b0;
        end else begin
            image_update <= (state == IOSSI_CYCLIC)
                && (cycle_timer == '0);
        end
    end

    // ------------------------------------------------------------
    // handshake outputs
    // ------------------------------------------------------------
    assign config_fetch_request = (state == IOSSI_FETCH);
    assign self_test_start = (state == IOSSI_SELFTEST);
    // both branches raised together, for the bring-up phases only
    assign bus_a_bring_up = (state == IOSSI_BUS_1)
        || (state == IOSSI_BUS_2);
    assign bus_b_bring_up = bus_a_bring_up;

    // ------------------------------------------------------------
    // indicators, registered
    // ------------------------------------------------------------
    // stop flag follows the sequencer, cleared only by reset
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            halted <= 1'b0;
        end else begin
            halted <= (next_state == IOSSI_HALT);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            leds <= IOSSI_LED_RESET;
        end else begin
            case (next_state)
                IOSSI_COORD_A: leds <= IOSSI_LED_COORD_A;
                IOSSI_COORD_B: leds <= IOSSI_LED_COORD_B;
                // dark while the fetch runs, a permitted gap
                IOSSI_FETCH: leds <= IOSSI_LED_RESET;
                IOSSI_SELFTEST: leds <= IOSSI_LED_SELFTEST;
                IOSSI_BUS_1: leds <= IOSSI_LED_BUS_1;
                IOSSI_BUS_2: leds <= IOSSI_LED_BUS_2;
                IOSSI_CYCLIC: leds <= IOSSI_LED_RUN;
                IOSSI_HALT: begin
                    // error lamp lit on every kind, marked means on
                    if (state == IOSSI_HALT) begin
                        leds <= halt_pattern(error_kind);
                    end else begin
                        leds <= halt_pattern(self_test_error);
                    end
                end
                default: leds <= IOSSI_LED_RESET;
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: tb/iossi_checker.sv */
// assertions on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module iossi_checker
    import iossi_pkg::*;
#(
    parameter int unsigned PHASE_CYCLES = IOSSI_PHASE_CYCLES,
    parameter int unsigned CYCLE_CYCLES = IOSSI_CYCLE_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // handshakes
    input wire logic config_fetch_request,
    input wire logic config_fetch_done,
    input wire logic self_test_start,
    input wire logic self_test_done,
    input wire iossi_pkg::iossi_error_t self_test_error,
    input wire logic bus_a_bring_up,
    input wire logic bus_b_bring_up,
    input wire logic bus_bring_up_done,
    // status
    input wire logic image_update,
    input wire logic halted,
    input wire iossi_pkg::iossi_leds_t leds
);
    import iossi_pkg::*;
    // cycles since the last refresh strobe, so any period can be checked
    logic [IOSSI_COUNT_WIDTH-1:0] since_image;
    logic image_seen;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            since_image <= '0;
            image_seen <= 1'b0;
        end else if (image_update) begin
            since_image <= '0;
            image_seen <= 1'b1;
        end else begin
            since_image <= since_image + 1'b1;
        end
    end
    function automatic logic [3:0] halt_pat(input iossi_error_t e);
        case (e)
            IOSSI_ERR_LOCAL_RAM: return 4'hc;
            IOSSI_ERR_DUAL_PORT_RAM: return 4'ha;
            IOSSI_ERR_ADDRESS_BUS: return 4'he;
            IOSSI_ERR_WATCHDOG: return 4'hf;
            default: return 4'h8;
        endcase
    endfunction
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence test_ends;
        self_test_start && self_test_done;
    endsequence
    halt_entry_a: assert property (
        test_ends ##0 self_test_error != IOSSI_ERR_NONE
        |=> halted && leds == halt_pat($past(self_test_error)))
        else $error("halt entry wrong");
    halt_hold_a: assert property (halted |=> halted)
        else $error("halt left");
    test_pass_a: assert property (
        test_ends ##0 self_test_error == IOSSI_ERR_NONE
        |=> leds == 4'h2 && bus_b_bring_up) else $error("pass wrong");
    fetch_first_a: assert property (
        $rose(self_test_start) |-> $past(config_fetch_request))
        else $error("test before fetch");
    test_lamps_a: assert property (
        self_test_start |-> leds == 4'h6) else $error("test lamps");
    run_only_a: assert property (
        image_update |-> leds == 4'h1) else $error("run lamps");
    image_gap_a: assert property (
        image_seen |-> image_update == (since_image == CYCLE_CYCLES - 1))
        else $error("image spacing");
    branch_pair_a: assert property (
        bus_a_bring_up |-> bus_b_bring_up && (leds == 4'h2 || leds == 4'h7))
        else $error("branch lamps");
    halt_quiet_a: assert property (
        halted |-> !bus_a_bring_up && !image_update) else $error("halt busy");
    coord_order_a: assert property (
        $rose(config_fetch_request) |-> $past(leds) == 4'h4)
        else $error("coordination lamps");
    run_entry_a: assert property (
        $fell(bus_a_bring_up) |-> leds == 4'h1 && !halted)
        else $error("run entry lamps");
endmodule
bind iossi_sequencer iossi_checker #(.PHASE_CYCLES(PHASE_CYCLES),
    .CYCLE_CYCLES(CYCLE_CYCLES)) chk (.clock(clock), .reset(reset),
    .config_fetch_request(config_fetch_request),
    .config_fetch_done(config_fetch_done), .self_test_start(self_test_start),
    .self_test_done(self_test_done), .self_test_error(self_test_error),
    .bus_a_bring_up(bus_a_bring_up), .bus_b_bring_up(bus_b_bring_up),
    .bus_bring_up_done(bus_bring_up_done), .image_update(image_update),
    .halted(halted), .leds(leds));
`default_nettype wire

/* File: tb/iossi_partner.sv */
// far side: host memory, self-test engine, bus branches
`timescale 1ns/1ps
`default_nettype none
module iossi_partner
    import iossi_pkg::*;
(
    // clock and scenario control
    input wire logic clock,
    input wire logic reset,
    input wire iossi_pkg::iossi_error_t fault,
    input wire logic [3:0] delay,
    // handshakes
    input wire logic config_fetch_request,
    input wire logic self_test_start,
    input wire logic bus_a_bring_up,
    output logic config_fetch_done,
    output logic self_test_done,
    output iossi_pkg::iossi_error_t self_test_error,
    output logic bus_bring_up_done
);
    import iossi_pkg::*;
    logic [3:0] waited;
    wire busy = config_fetch_request || self_test_start || bus_a_bring_up;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            waited <= 4'h0;
        end else begin
            waited <= (busy && waited != delay) ? waited + 4'h1 : 4'h0;
        end
    end
    assign config_fetch_done = config_fetch_request && waited == delay;
    assign self_test_done = self_test_start && waited == delay;
    // result inverted outside done, so nothing may lean on a stale code
    assign self_test_error = self_test_done ? fault : iossi_error_t'(~fault);
    // branches report ready one cycle after the same lag, registered, held until bring-up ends
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            bus_bring_up_done <= 1'b0;
        end else begin
            bus_bring_up_done <= bus_a_bring_up
                && (bus_bring_up_done || waited == delay);
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb_iossi_sequencer.sv */
// self-checking bench for the startup sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_iossi_sequencer;
    import iossi_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    iossi_error_t fault = IOSSI_ERR_NONE;
    logic [3:0] delay = 4'h1;
    logic f_req, f_done, t_start, t_done, bus_a, bus_b, b_done, image, halted;
    iossi_error_t t_err;
    iossi_leds_t leds;
    int mismatches = 0;
    int comparisons = 0;
    int count;
    logic [3:0] halt_table [1:7] = '{4'hc, 4'ha, 4'he, 4'h8, 4'hf, 4'h8, 4'h8};
    always #12.5 clock = ~clock;
    iossi_sequencer #(.PHASE_CYCLES(4), .CYCLE_CYCLES(4)) dut (
        .clock(clock), .reset(reset), .config_fetch_request(f_req),
        .config_fetch_done(f_done), .self_test_start(t_start),
        .self_test_done(t_done), .self_test_error(t_err),
        .bus_a_bring_up(bus_a), .bus_b_bring_up(bus_b),
        .bus_bring_up_done(b_done), .image_update(image),
        .halted(halted), .leds(leds));
    iossi_partner far (.clock(clock), .reset(reset), .fault(fault),
        .delay(delay), .config_fetch_request(f_req), .self_test_start(t_start),
        .config_fetch_done(f_done), .self_test_done(t_done),
        .self_test_error(t_err), .bus_a_bring_up(bus_a),
        .bus_bring_up_done(b_done));
    task automatic test_done;
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // dark gaps between phases are skipped, bounded by count
    task automatic await_leds(input logic [3:0] exp);
        count = 0;
        while (leds !== exp && count < 100) begin
            @(negedge clock);
            count++;
        end
        check(leds, exp);
        if (leds !== exp) test_done();
    endtask
    task automatic restart(input iossi_error_t kind, input logic [3:0] lag);
        reset = 1'b1;
        fault = kind;
        delay = lag;
        repeat (12) @(negedge clock);
        reset = 1'b0;
    endtask
    initial begin
        restart(IOSSI_ERR_NONE, 4'h1);
        check(leds, 4'h0);
        await_leds(4'h4);
        await_leds(4'h6);
        await_leds(4'h2);
        await_leds(4'h7);
        await_leds(4'h1);
        count = 0;
        repeat (40) begin
            @(negedge clock);
            if (image === 1'b1) count++;
        end
        check(count[3:0], 4'ha);
        check({bus_a, bus_b, image, halted}, 4'h0);
        // late branch ready stretches the last bring-up phase
        restart(IOSSI_ERR_NONE, 4'h9);
        await_leds(4'h2);
        await_leds(4'h7);
        repeat (7) @(negedge clock);
        check(leds, 4'h7);
        await_leds(4'h1);
        for (int k = 1; k <= 7; k++) begin
            restart(iossi_error_t'(k), 4'h5);
            await_leds(4'h6);
            await_leds(halt_table[k]);
            repeat (50) @(negedge clock);
            check(leds, halt_table[k]);
            check({bus_a, bus_b, image, halted}, 4'h1);
        end
        test_done();
    end
endmodule
`default_nettype wire
